/* File: pmcg_defs.svh */
// constants for the power mode and clock gating block
`ifndef PMCG_DEFS_SVH
`define PMCG_DEFS_SVH

// clock source select codes
`define PMCG_SRC_FAST 2'h0
`define PMCG_SRC_LOWP 2'h1
`define PMCG_SRC_SOSC 2'h2
`define PMCG_SRC_POSC 2'h3
// reset values
`define PMCG_RST_SRC 2'h0
`define PMCG_RST_FAST_DIV 3'h0
`define PMCG_RST_PB_DIV 2'h0
// wake count; the restarted source runs this many cycles plus one before the cpu clock returns
`define PMCG_WAKE_WAIT 8'h10

`endif

/* File: pmcg_div.sv */
// programmable power-of-two enable divider
`timescale 1ns/10ps
`default_nettype none
module pmcg_div #(
   parameter int WIDTH = 7
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // control
   input wire logic run,
   input wire logic [2:0] shift,
   // one-cycle tick every 2^shift cycles
   output logic tick
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic tick;
   } pmcg_div_st_t;

   pmcg_div_st_t s_reg, s_next;
   logic [WIDTH-1:0] limit;

   // terminal count from the shift amount
   always_comb begin
      limit = WIDTH'((1 << shift) - 1);
      s_next = s_reg;
      s_next.tick = 1'b0;
      if (!run) begin
         s_next.cnt = '0;
      end else if (s_reg.cnt >= limit) begin
         s_next.cnt = '0;
         s_next.tick = 1'b1;
      end else begin
         s_next.cnt = s_reg.cnt + WIDTH'(1);
      end
   end

   // state register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick = s_reg.tick;
endmodule : pmcg_div
`default_nettype wire

/* File: pmcg_gate.sv */
// per-module clock enable gating
`timescale 1ns/10ps
`default_nettype none
module pmcg_gate #(
   parameter int N = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // sources
   input wire logic pb_tick,
   input wire logic sys_on,
   input wire logic [N-1:0] mod_disable,
   input wire logic [N-1:0] mod_own_clock,
   // enables to each module
   output logic [N-1:0] mod_clk_en
);
   typedef struct packed {
      logic [N-1:0] en;
   } pmcg_gate_st_t;

   pmcg_gate_st_t s_reg, s_next;

   // one enable per module
   always_comb begin
      s_next = s_reg;
      for (int i = 0; i < N; i++) begin
         // [RULE8] disabled modules gated
         // [RULE10] own-clock modules survive sleep
         s_next.en[i] = !mod_disable[i] && (mod_own_clock[i] || (sys_on && pb_tick));
      end
   end

   // state register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign mod_clk_en = s_reg.en;
endmodule : pmcg_gate
`default_nettype wire

/* File: pmcg_pkg.sv */
// types for the power mode and clock gating block
package pmcg_pkg;

   typedef enum logic [1:0] {
      PMCG_RUN,
      PMCG_IDLE,
      PMCG_SLEEP,
      PMCG_WAKE
   } pmcg_state_t;

   // software control settings
   typedef struct packed {
      logic [1:0] src_sel;
      logic [2:0] fast_div;
      logic [1:0] pb_div;
      logic sleep_sel;
      logic enter;
   } pmcg_ctrl_t;

   // enable set for the gated clocks
   typedef struct packed {
      logic cpu_en;
      logic sys_en;
      logic pb_en;
   } pmcg_gate_t;

endpackage : pmcg_pkg

/* File: pmcg_top.sv */
// power mode sequencing and clock source selection
`timescale 1ns/10ps
`default_nettype none
`include "pmcg_defs.svh"

// Function
// [RULE1] modes change only on software enter command or enabled wake
// [RULE2] run clock from fast rc with postscaler, low-power rc or secondary
// [RULE3] power cut by slower cpu clock, bus clock, module gating
// [RULE4] peripheral bus clock is programmable fraction of system clock; pb_div here divides the block clock, not the postscaled system clock
// [RULE5] idle and sleep both stop cpu clock, with any source
// [RULE6] primary oscillator idle keeps that oscillator running
// [RULE7] idle system clock taken from the currently selected source
// [RULE8] peripherals keep clocks in idle unless individually disabled
// [RULE9] sleep halts cpu, system clock source and its peripherals
// [RULE10] peripherals on dedicated clocks keep running during sleep
// [RULE11] enabled wake ends idle or sleep, restarts source, then cpu
module pmcg_top #(
   parameter int NMOD = 8,
   parameter logic [7:0] WAKE_WAIT = `PMCG_WAKE_WAIT
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // software control
   input wire pmcg_pkg::pmcg_ctrl_t ctrl,
   input wire logic [NMOD-1:0] mod_disable,
   input wire logic [NMOD-1:0] mod_own_clock,
   // wake sources
   input wire logic [NMOD-1:0] wake_req,
   input wire logic [NMOD-1:0] wake_en,
   // oscillator enables and selected source
   output logic fast_internal_rc_osc_en,
   output logic low_power_rc_osc_en,
   output logic sosc_en,
   output logic posc_en,
   output logic [1:0] system_clock_src,
   // clock enables
   output pmcg_pkg::pmcg_gate_t gate,
   output logic [NMOD-1:0] mod_clk_en,
   // status
   output pmcg_pkg::pmcg_state_t mode
);
   import pmcg_pkg::*;

   typedef struct packed {
      pmcg_state_t st;
      logic [1:0] src;
      logic [2:0] fast_div;
      logic [1:0] pb_div;
      logic [7:0] wait_cnt;
      logic [3:0] osc_en;
   } pmcg_top_st_t;

   pmcg_top_st_t s_reg, s_next;
   logic sys_tick;
   logic pb_tick;
   logic sys_on;
   logic wake_hit;
   logic [2:0] sys_shift;

   // postscaler applies only to the fast rc source
   assign sys_shift = (s_reg.src == `PMCG_SRC_FAST) ? s_reg.fast_div : 3'h0;
   assign sys_on = (s_reg.st != PMCG_SLEEP) && (s_reg.st != PMCG_WAKE);
   assign wake_hit = |(wake_req & wake_en);

   // [RULE2] fast rc postscaler
   pmcg_div #(.WIDTH(7)) u_sys_div (
      .clock(clock),
      .nrst(nrst),
      .run(sys_on),
      .shift(sys_shift),
      .tick(sys_tick)
   );

   // [RULE4] bus clock fraction
   pmcg_div #(.WIDTH(7)) u_pb_div (
      .clock(clock),
      .nrst(nrst),
      .run(sys_on),
      .shift({1'b0, s_reg.pb_div}),
      .tick(pb_tick)
   );

   // [RULE3] module clock gating
   pmcg_gate #(.N(NMOD)) u_gate (
      .clock(clock),
      .nrst(nrst),
      .pb_tick(pb_tick),
      .sys_on(sys_on),
      .mod_disable(mod_disable),
      .mod_own_clock(mod_own_clock),
      .mod_clk_en(mod_clk_en)
   );

   // mode sequencer
   always_comb begin
      s_next = s_reg;
      unique case (s_reg.st)
         PMCG_RUN: begin
            // [RULE1] software selects run settings
            s_next.src = ctrl.src_sel;
            s_next.fast_div = ctrl.fast_div;
            s_next.pb_div = ctrl.pb_div;
            // [RULE5] halt cpu on request
            if (ctrl.enter) begin
               s_next.st = ctrl.sleep_sel ? PMCG_SLEEP : PMCG_IDLE;
            end
         end
         PMCG_IDLE: begin
            // [RULE11] wake from idle
            if (wake_hit) begin
               s_next.st = PMCG_RUN;
            end
         end
         PMCG_SLEEP: begin
            // [RULE11] wake restarts source
            if (wake_hit) begin
               s_next.st = PMCG_WAKE;
               s_next.wait_cnt = WAKE_WAIT;
            end
         end
         PMCG_WAKE: begin
            if (s_reg.wait_cnt == 8'h00) begin
               s_next.st = PMCG_RUN;
            end else begin
               s_next.wait_cnt = s_reg.wait_cnt - 8'h01;
            end
         end
      endcase
      // oscillator enables, selected source only
      s_next.osc_en = '0;
      // [RULE9] sleep stops the source
      if (s_next.st != PMCG_SLEEP) begin
         // [RULE6] [RULE7] selected source runs
         s_next.osc_en[s_next.src] = 1'b1;
      end
   end

   // state register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_reg.st <= PMCG_RUN;
         s_reg.src <= `PMCG_RST_SRC;
         s_reg.fast_div <= `PMCG_RST_FAST_DIV;
         s_reg.pb_div <= `PMCG_RST_PB_DIV;
         s_reg.wait_cnt <= 8'h00;
         s_reg.osc_en <= 4'h1;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs from registered state
   assign fast_internal_rc_osc_en = s_reg.osc_en[`PMCG_SRC_FAST];
   assign low_power_rc_osc_en = s_reg.osc_en[`PMCG_SRC_LOWP];
   assign sosc_en = s_reg.osc_en[`PMCG_SRC_SOSC];
   assign posc_en = s_reg.osc_en[`PMCG_SRC_POSC];
   assign system_clock_src = s_reg.src;
   assign mode = s_reg.st;

   // [RULE5] cpu clock only in run
   always_comb begin
      gate.cpu_en = (s_reg.st == PMCG_RUN) && sys_tick;
      gate.sys_en = sys_on && sys_tick;
      gate.pb_en = sys_on && pb_tick;
   end
endmodule : pmcg_top
`default_nettype wire

/* File: pmcg_top_chk.sv */
// assertions on the pmcg_top ports
`timescale 1ns/10ps
`default_nettype none
`include "pmcg_defs.svh"
module pmcg_top_chk #(
   parameter int NMOD = 8,
   parameter logic [7:0] WAKE_WAIT = 8'h10
) (
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // software control
   input wire pmcg_pkg::pmcg_ctrl_t ctrl,
   input wire logic [NMOD-1:0] mod_disable,
   input wire logic [NMOD-1:0] mod_own_clock,
   // sources and enables
   input wire logic fast_internal_rc_osc_en,
   input wire logic low_power_rc_osc_en,
   input wire logic sosc_en,
   input wire logic posc_en,
   input wire logic [1:0] system_clock_src,
   input wire pmcg_pkg::pmcg_gate_t gate,
   input wire logic [NMOD-1:0] mod_clk_en,
   input wire pmcg_pkg::pmcg_state_t mode
);
   import pmcg_pkg::*;
   logic [3:0] osc;
   // all oscillator enables
   assign osc = {posc_en, sosc_en, low_power_rc_osc_en, fast_internal_rc_osc_en};
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   a_run_holds: assert property (mode == PMCG_RUN && !ctrl.enter |=> mode == PMCG_RUN) else $error("run left");
   a_one_source: assert property (mode != PMCG_SLEEP |-> $onehot(osc)) else $error("not one source");
   a_idle_cpu_off: assert property ((mode == PMCG_IDLE) [*3] |-> !gate.cpu_en) else $error("cpu in idle");
   a_posc_idle: assert property (mode == PMCG_IDLE && system_clock_src == `PMCG_SRC_POSC |-> posc_en)
      else $error("primary stopped");
   a_off_gated: assert property ((mod_disable & $past(mod_disable) & mod_clk_en) == '0)
      else $error("disabled clocked");
   a_sleep_dark: assert property (mode == PMCG_SLEEP |-> osc == 4'h0) else $error("source in sleep");
   a_sleep_gated: assert property ((mode == PMCG_SLEEP) [*3]
      |-> gate == '0 && (mod_clk_en & ~mod_own_clock) == '0) else $error("clock in sleep");
   a_wake_ends: assert property ($rose(mode == PMCG_WAKE)
      |-> (mode == PMCG_WAKE) [*2] ##[1:300] mode == PMCG_RUN) else $error("wake stuck");
   c_idle: cover property ((mode == PMCG_IDLE) [*3]);
   c_sleep: cover property ((mode == PMCG_SLEEP) [*3]);
   c_wake: cover property (mode == PMCG_WAKE);
endmodule : pmcg_top_chk

bind pmcg_top pmcg_top_chk #(.NMOD(NMOD), .WAKE_WAIT(WAKE_WAIT)) u_chk (.*);
`default_nettype wire

/* File: test_power_mode_clock_gating.sv */
// bench for the power mode clock gating block
`timescale 1ns/10ps
`default_nettype none
module test_power_mode_clock_gating;
   import pmcg_pkg::*;
   localparam logic [7:0] WW = 8'h02;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   pmcg_ctrl_t ctrl = '0;
   logic [7:0] mod_disable = '0, mod_own_clock = '0, wake_req = '0, wake_en = '0, mod_clk_en;
   logic fast_internal_rc_osc_en, low_power_rc_osc_en, sosc_en, posc_en;
   logic [1:0] system_clock_src;
   pmcg_gate_t gate;
   pmcg_state_t mode;
   logic [3:0] osc;
   logic [10:0] en_all;
   int errors = 0;
   int checked = 0;
   int c;
   int i;
   // grouped outputs for counting
   assign osc = {posc_en, sosc_en, low_power_rc_osc_en, fast_internal_rc_osc_en};
   assign en_all = {mod_clk_en, gate};
   pmcg_top #(.NMOD(8), .WAKE_WAIT(WW)) DUT (.*);
   // 40 MHz clock
   initial begin
      forever #12.5 clock = ~clock;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      @(negedge clock);
      checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic go(input logic [1:0] s, input logic [2:0] f, input logic [1:0] p, input logic sl, input logic en);
      @(posedge clock);
      ctrl <= {s, f, p, sl, en};
   endtask : go
   // count pulses of one enable
   task automatic cnt(input int s, input int n);
      c = 0;
      repeat (n) begin
         @(negedge clock);
         c += (en_all[s] === 1'b1);
      end
   endtask : cnt
   task automatic wt(input pmcg_state_t m);
      i = 0;
      while (mode !== m) begin
         @(negedge clock);
         i++;
         if (i > 60) begin
            errors++;
            end_of_test();
         end
      end
   endtask : wt
   task automatic end_of_test();
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test
   // main sequence
   initial begin
      repeat (12) @(posedge clock);
      chk("osc", 8'h01, osc);
      @(posedge clock);
      nrst <= 1'b1;
      for (int k = 0; k < 4; k++) begin
         go(2'(k), 3'h0, 2'h0, 1'b0, 1'b0);
         repeat (4) @(posedge clock);
         chk("osc", 8'h01 << k, osc);
      end
      for (int k = 0; k < 4; k++) begin
         go(2'h0, 3'h0, 2'(k), 1'b0, 1'b0);
         repeat (20) @(posedge clock);
         cnt(0, 64);
         chk("pb", 8'(64 >> k), 8'(c));
         go(2'h0, 3'(k), 2'h0, 1'b0, 1'b0);
         repeat (20) @(posedge clock);
         cnt(2, 64);
         chk("cpu", 8'(64 >> k), 8'(c));
      end
      go(2'h3, 3'h0, 2'h0, 1'b0, 1'b0);
      mod_disable <= 8'h02;
      mod_own_clock <= 8'h04;
      wake_en <= 8'h01;
      wake_req <= 8'h10;
      go(2'h3, 3'h0, 2'h0, 1'b0, 1'b1);
      go(2'h3, 3'h0, 2'h0, 1'b0, 1'b0);
      wt(PMCG_IDLE);
      chk("osc", 8'h08, osc);
      cnt(2, 16);
      chk("cpu", 8'h00, 8'(c));
      cnt(0, 16);
      chk("pb", 8'h10, 8'(c));
      cnt(4, 16);
      chk("off", 8'h00, 8'(c));
      chk("src", 8'h03, 8'(system_clock_src));
      cnt(1, 16);
      chk("sys", 8'h10, 8'(c));
      chk("mode", 8'(PMCG_IDLE), 8'(mode));
      @(posedge clock);
      wake_req <= 8'h01;
      wt(PMCG_RUN);
      chk("mode", 8'(PMCG_RUN), 8'(mode));
      @(posedge clock);
      wake_req <= 8'h00;
      go(2'h0, 3'h0, 2'h0, 1'b1, 1'b1);
      go(2'h0, 3'h0, 2'h0, 1'b1, 1'b0);
      wt(PMCG_SLEEP);
      chk("osc", 8'h00, osc);
      cnt(0, 16);
      chk("pb", 8'h00, 8'(c));
      cnt(5, 16);
      chk("own", 8'h10, 8'(c));
      @(posedge clock);
      wake_req <= 8'h01;
      wt(PMCG_WAKE);
      i = 0;
      while (mode === PMCG_WAKE && i < 40) begin
         @(negedge clock);
         i++;
      end
      chk("wake", WW + 8'h01, 8'(i));
      repeat (4) @(posedge clock);
      cnt(2, 16);
      chk("cpu", 8'h10, 8'(c));
      end_of_test();
   end
endmodule : test_power_mode_clock_gating
`default_nettype wire
